// ---- src/system_clock_prescale_sleep_ctrl.sv ----
`timescale 1ns/1ps
`include "clk_sleep_defs.svh"
module system_clock_prescale_sleep_ctrl #(
	parameter int RST_4MS_CYC = `CSC_T_4MS * `CSC_CLK_KHZ,
	parameter int RST_64MS_CYC = `CSC_T_64MS * `CSC_CLK_KHZ
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic [3:0] clock_source_select_fuses_i,
	input wire logic [1:0] startup_time_fuses_i,
	input wire logic clock_output_fuse_i,
	input wire logic divide_by_eight_fuse_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic sleep_instr_i,
	input wire logic wake_irq_i,
	input wire logic port_out_i,
	input wire logic port_oe_i,
	output logic low_power_osc_sel_o,
	output logic core_resetn_o,
	output logic clk_cpu_en_o,
	output logic clk_flash_en_o,
	output logic clk_io_en_o,
	output logic clk_adc_en_o,
	output logic cpu_halt_o,
	output logic irq_service_o,
	output logic sleeping_o,
	output csc_pkg::sleep_mode_e sleep_mode_o,
	output logic osc_stop_o,
	output logic bod_off_o,
	output logic clock_output_pin_o,
	output logic clock_output_pin_oe_o,
	output logic pull_up_disable_o,
	output logic [1:0] int0_sense_o
);
	import csc_pkg::*;

	if (RST_4MS_CYC < 1 || RST_64MS_CYC < RST_4MS_CYC ||
			RST_64MS_CYC + `CSC_RST_CK > 20'hfffff) begin : g_chk
		$error("reset delay counts out of range");
	end

	// ------------------------------
	// Functions
	// ------------------------------
	// Reserved codes above eight clamp to the slowest rate
	function automatic logic [7:0] div_mask(input logic [3:0] code);
		logic [8:0] m;
		m = 9'h0;
		if (code >= `CSC_SEL_MAX) begin
			m = 9'h0ff;
		end else begin
			m = (9'h001 << code) - 9'h001;
		end
		return m[7:0];
	endfunction

	function automatic logic at_off(input logic [3:0] a,
			input logic [3:0] off);
		return a == off;
	endfunction

	// ------------------------------
	// Avalon slave
	// ------------------------------
	logic ack_q;
	logic req;
	logic wr_go;
	logic wr_div;
	logic wr_slp;
	logic [7:0] wd;

	assign req = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = req & ~ack_q;
	assign wr_go = avs_write_i & ack_q & avs_byteenable_i[0];
	assign wd = avs_writedata_i[7:0];
	assign wr_div = wr_go & at_off(avs_address_i, `CSC_OFF_DIV);
	assign wr_slp = wr_go & at_off(avs_address_i, `CSC_OFF_SLP);

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	// ------------------------------
	// Prescaler
	// ------------------------------
	logic [3:0] sel;
	logic [3:0] act;
	logic pend;
	logic [7:0] cnt;
	logic ce;
	logic tick;
	logic phase_q;
	logic pce_q;
	logic [2:0] pce_cnt;

	assign tick = cnt >= div_mask(act);

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			cnt <= 8'h00;
			ce <= 1'b0;
			phase_q <= 1'b0;
		end else begin
			ce <= tick;
			phase_q <= tick | (cnt < (div_mask(act) >> 1));
			if (tick) begin
				cnt <= 8'h00;
			end else begin
				cnt <= cnt + 8'h01;
			end
		end
	end

	// New setting waits for the end of the running period, so
	// neither old nor new period is ever cut short
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			pend <= 1'b0;
			act <= divide_by_eight_fuse_i ? `CSC_SEL_DIV8 : `CSC_SEL_RST;
		end else begin
			if (wr_div && pce_q && !wd[`CSC_PCE_BIT]) begin
				pend <= 1'b1;
			end else if (tick) begin
				pend <= 1'b0;
			end
			if (pend && tick) begin
				act <= sel;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			sel <= divide_by_eight_fuse_i ? `CSC_SEL_DIV8 : `CSC_SEL_RST;
		end else if (wr_div && pce_q && !wd[`CSC_PCE_BIT]) begin
			sel <= wd[3:0];
		end
	end

	// Window counts divided cycles, as the core sees them
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			pce_q <= 1'b0;
			pce_cnt <= 3'd0;
		end else if (wr_div && !pce_q && wd == `CSC_PCE_ONLY) begin
			pce_q <= 1'b1;
			pce_cnt <= 3'd0;
		end else if (wr_div && pce_q && !wd[`CSC_PCE_BIT]) begin
			pce_q <= 1'b0;
		end else if (pce_q && ce) begin
			if (pce_cnt == `CSC_PCE_WIN - 3'd1) begin
				pce_q <= 1'b0;
			end
			pce_cnt <= pce_cnt + 3'd1;
		end
	end

	// ------------------------------
	// Sleep control register
	// ------------------------------
	logic [7:0] slp_q;
	logic brownout_sleep_off_unlock_q;
	logic [2:0] brownout_sleep_off_unlock_cnt;
	logic brownout_sleep_off_q;
	logic [2:0] brownout_sleep_off_cnt;
	logic brownout_sleep_off_act;

	assign brownout_sleep_off_act = brownout_sleep_off_q && brownout_sleep_off_cnt >= `CSC_BROWNOUT_SLEEP_OFF_LAT;

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			slp_q <= `CSC_SLP_RST;
		end else if (wr_slp) begin
			slp_q <= wd & `CSC_SLP_KEEP;
		end
	end

	// Arming by software beats the hardware time-out
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			brownout_sleep_off_unlock_q <= 1'b0;
			brownout_sleep_off_unlock_cnt <= 3'd0;
		end else if (wr_slp && wd[`CSC_BROWNOUT_SLEEP_OFF_BIT] && wd[`CSC_BROWNOUT_SLEEP_OFF_UNLOCK_BIT]) begin
			brownout_sleep_off_unlock_q <= 1'b1;
			brownout_sleep_off_unlock_cnt <= 3'd0;
		end else if (wr_slp && !wd[`CSC_BROWNOUT_SLEEP_OFF_UNLOCK_BIT]) begin
			brownout_sleep_off_unlock_q <= 1'b0;
		end else if (brownout_sleep_off_unlock_q && ce) begin
			if (brownout_sleep_off_unlock_cnt == `CSC_BROWNOUT_SLEEP_OFF_UNLOCK_WIN - 3'd1) begin
				brownout_sleep_off_unlock_q <= 1'b0;
			end
			brownout_sleep_off_unlock_cnt <= brownout_sleep_off_unlock_cnt + 3'd1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			brownout_sleep_off_q <= 1'b0;
			brownout_sleep_off_cnt <= 3'd0;
		end else if (wr_slp && brownout_sleep_off_unlock_q && wd[`CSC_BROWNOUT_SLEEP_OFF_BIT] &&
				!wd[`CSC_BROWNOUT_SLEEP_OFF_UNLOCK_BIT]) begin
			brownout_sleep_off_q <= 1'b1;
			brownout_sleep_off_cnt <= 3'd0;
		end else if (brownout_sleep_off_q && ce) begin
			if (brownout_sleep_off_cnt == `CSC_BROWNOUT_SLEEP_OFF_LAT + `CSC_BROWNOUT_SLEEP_OFF_LIFE - 3'd1) begin
				brownout_sleep_off_q <= 1'b0;
			end
			brownout_sleep_off_cnt <= brownout_sleep_off_cnt + 3'd1;
		end
	end

	// ------------------------------
	// Reset delay and sleep sequencer
	// ------------------------------
	ctl_state_e state;
	sleep_mode_e mode_q;
	logic [19:0] rst_cnt;
	logic [19:0] rst_tgt;
	logic [2:0] wcnt;
	logic bod_off_q;
	logic irq_q;

	// Reserved start-up code takes the longest delay
	always_comb begin
		unique case (startup_time_fuses_i)
			2'b00: rst_tgt = 20'(`CSC_RST_CK);
			2'b01: rst_tgt = 20'(`CSC_RST_CK + RST_4MS_CYC);
			2'b10: rst_tgt = 20'(`CSC_RST_CK + RST_64MS_CYC);
			2'b11: rst_tgt = 20'(`CSC_RST_CK + RST_64MS_CYC);
		endcase
	end

	// A reset lands here from any state, sleep included
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			state <= ST_RESET;
			rst_cnt <= 20'h00000;
			wcnt <= 3'd0;
			mode_q <= SM_IDLE;
			bod_off_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			irq_q <= 1'b0;
			unique case (state)
				ST_RESET: begin
					rst_cnt <= rst_cnt + 20'h00001;
					if (rst_cnt >= rst_tgt - 20'h00001) begin
						state <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (sleep_instr_i && slp_q[`CSC_SE_BIT]) begin
						state <= ST_SLEEP;
						mode_q <= sleep_mode_e'(slp_q[4:3]);
						bod_off_q <= brownout_sleep_off_act;
					end
				end
				ST_SLEEP: begin
					wcnt <= 3'd0;
					if (wake_irq_i) begin
						bod_off_q <= 1'b0;
						if (mode_q[1]) begin
							state <= ST_START;
						end else begin
							state <= ST_HALT;
						end
					end
				end
				ST_START: begin
					if (wcnt == `CSC_PD_START_CK - 3'd1) begin
						state <= ST_HALT;
						wcnt <= 3'd0;
					end else begin
						wcnt <= wcnt + 3'd1;
					end
				end
				ST_HALT: begin
					if (ce) begin
						if (wcnt == `CSC_HALT_CYC - 3'd1) begin
							state <= ST_RUN;
							irq_q <= 1'b1;
						end
						wcnt <= wcnt + 3'd1;
					end
				end
				default: state <= ST_RESET;
			endcase
		end
	end

	// ------------------------------
	// Clock enables and pin
	// ------------------------------
	logic clock_output_pin_q;

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			clock_output_pin_q <= 1'b0;
		end else begin
			clock_output_pin_q <= clock_output_fuse_i && state != ST_RESET;
		end
	end

	// Undivided setting has no flop-made phase, so the pin
	// takes the master clock itself through the mux
	assign clock_output_pin_o = (clock_output_pin_q & resetn_i) ?
			(act == 4'h0 ? clk_sys_i : phase_q) : port_out_i;
	assign clock_output_pin_oe_o = (clock_output_pin_q & resetn_i) | port_oe_i;

	assign clk_cpu_en_o = ce && state == ST_RUN;
	assign clk_flash_en_o = ce && state == ST_RUN;
	assign clk_io_en_o = ce && !osc_stop_o;
	assign clk_adc_en_o = ce && !osc_stop_o;
	assign low_power_osc_sel_o =
			clock_source_select_fuses_i == `CSC_LPOSC_CODE;
	assign core_resetn_o = state != ST_RESET;
	assign cpu_halt_o = state != ST_RUN;
	assign sleeping_o = state == ST_SLEEP;
	assign sleep_mode_o = mode_q;
	assign osc_stop_o = state == ST_SLEEP && mode_q[1];
	assign bod_off_o = bod_off_q && state == ST_SLEEP;
	assign irq_service_o = irq_q;
	assign pull_up_disable_o = slp_q[6];
	assign int0_sense_o = slp_q[1:0];

	// ------------------------------
	// Read data
	// ------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			avs_readdata_o <= 32'h00000000;
		end else if (avs_read_i && !ack_q) begin
			if (at_off(avs_address_i, `CSC_OFF_DIV)) begin
				avs_readdata_o <= {24'h000000, pce_q, 3'h0, sel};
			end else if (at_off(avs_address_i, `CSC_OFF_SLP)) begin
				avs_readdata_o <= {24'h000000, brownout_sleep_off_q, slp_q[6:3],
						brownout_sleep_off_unlock_q, slp_q[1:0]};
			end else if (at_off(avs_address_i, `CSC_OFF_STAT)) begin
				avs_readdata_o <= {26'h0000000, low_power_osc_sel_o,
						pend, bod_off_q, mode_q, sleeping_o};
			end else begin
				avs_readdata_o <= 32'h00000000;
			end
		end
	end

	// ------------------------------
	// Assertions
	// ------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	sequence s_wake_pd;
		state == ST_SLEEP && wake_irq_i && mode_q[1];
	endsequence

	sequence s_brownout_sleep_off_arm;
		wr_slp && brownout_sleep_off_unlock_q && wd[`CSC_BROWNOUT_SLEEP_OFF_BIT] && !wd[`CSC_BROWNOUT_SLEEP_OFF_UNLOCK_BIT];
	endsequence

	AST_PD_START:
	assert property (s_wake_pd |=> (state == ST_START) [*6]
			##1 state == ST_HALT)
		else $error("power-down start-up not six clocks");

	AST_CLOCK_OUTPUT_PIN_OFF:
	assert property (state == ST_RESET |->
			clock_output_pin_oe_o == port_oe_i)
		else $error("clock driven on pin during reset");

	AST_CLOCK_OUTPUT_PIN_ON:
	assert property (clock_output_fuse_i && $past(clock_output_fuse_i)
			&& state == ST_RUN && $past(state) == ST_RUN
			|-> clock_output_pin_oe_o)
		else $error("clock output not driven");

	AST_PCE_GUARD:
	assert property (wr_div && !pce_q && wd != `CSC_PCE_ONLY |=> !pce_q)
		else $error("change enable set by wrong write");

	AST_PCE_TIMEOUT:
	assert property (pce_q && ce && pce_cnt == 3'd3 && !wr_div |=> !pce_q)
		else $error("change enable outlived four cycles");

	AST_RSV_ZERO:
	assert property (avs_read_i && ack_q &&
			at_off(avs_address_i, `CSC_OFF_DIV)
			|-> avs_readdata_o[6:4] == 3'h0)
		else $error("reserved divider bits not zero");

	AST_SEL_LOCK:
	assert property (wr_div && !pce_q |=> $stable(sel))
		else $error("select changed without enable");

	AST_SWITCH:
	assert property (pend && tick |=> act == $past(sel) && cnt == 8'h00)
		else $error("divider switch off a period boundary");

	AST_SLEEP_GATE:
	assert property (state == ST_RUN && sleep_instr_i &&
			!slp_q[`CSC_SE_BIT] |=> state == ST_RUN)
		else $error("sleep entered without enable");

	AST_SERVE:
	assert property (irq_service_o |-> $past(state) == ST_HALT &&
			state == ST_RUN)
		else $error("interrupt served without halt");

	AST_BROWNOUT_SLEEP_OFF_ARM:
	assert property (s_brownout_sleep_off_arm |=> brownout_sleep_off_q && !brownout_sleep_off_act ##1 brownout_sleep_off_q)
		else $error("brownout off not armed");

	AST_BROWNOUT_SLEEP_OFF_SLEEP:
	assert property (state == ST_RUN && sleep_instr_i &&
			slp_q[`CSC_SE_BIT] |=> bod_off_q == $past(brownout_sleep_off_act))
		else $error("brownout off not taken at sleep");

endmodule // system_clock_prescale_sleep_ctrl

// ---- src/clk_sleep_defs.svh ----
`ifndef CLK_SLEEP_DEFS_SVH
`define CLK_SLEEP_DEFS_SVH

// ------------------------------
// Register map and fields
// ------------------------------
`define CSC_OFF_DIV 4'h0
`define CSC_OFF_SLP 4'h4
`define CSC_OFF_STAT 4'h8
`define CSC_PCE_BIT 7
`define CSC_PCE_ONLY 8'h80
`define CSC_SEL_RST 4'h0
`define CSC_SEL_DIV8 4'h3
`define CSC_SEL_MAX 4'h8
`define CSC_BROWNOUT_SLEEP_OFF_BIT 7
`define CSC_SE_BIT 5
`define CSC_BROWNOUT_SLEEP_OFF_UNLOCK_BIT 2
`define CSC_SLP_RST 8'h00
`define CSC_SLP_KEEP 8'h7b
`define CSC_LPOSC_CODE 4'h3

// ------------------------------
// Timing
// ------------------------------
`define CSC_PCE_WIN 3'd4
`define CSC_BROWNOUT_SLEEP_OFF_UNLOCK_WIN 3'd4
`define CSC_BROWNOUT_SLEEP_OFF_LAT 3'd3
`define CSC_BROWNOUT_SLEEP_OFF_LIFE 3'd3
`define CSC_HALT_CYC 3'd4
`define CSC_PD_START_CK 3'd6
`define CSC_RST_CK 14
`define CSC_CLK_KHZ 10000
`define CSC_T_4MS 4
`define CSC_T_64MS 64
`endif

// ---- src/csc_pkg.sv ----
package csc_pkg;
	typedef enum logic [2:0] {
		ST_RESET = 3'b000,
		ST_RUN = 3'b001,
		ST_SLEEP = 3'b010,
		ST_START = 3'b011,
		ST_HALT = 3'b100
	} ctl_state_e;
	typedef enum logic [1:0] {
		SM_IDLE = 2'b00,
		SM_ADC_NR = 2'b01,
		SM_PWR_DOWN = 2'b10,
		SM_STANDBY = 2'b11
	} sleep_mode_e;
endpackage

// ---- verification/tb.sv ----
`timescale 1ns/1ps
module tb;
	import csc_pkg::*;
	// --------------------------------
	// Signals
	// --------------------------------
	logic clk_sys_i = 0, resetn_i = 0, clock_output_fuse_i = 1;
	logic divide_by_eight_fuse_i = 0, avs_read_i = 0, avs_write_i = 0;
	logic sleep_instr_i = 0, wake_irq_i = 0, port_out_i = 0, port_oe_i = 0;
	logic [3:0] clock_source_select_fuses_i = 4'h3, avs_address_i = 4'h0;
	logic [3:0] avs_byteenable_i = 4'hf;
	logic [1:0] startup_time_fuses_i = 2'h0;
	logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
	logic avs_waitrequest_o, low_power_osc_sel_o, core_resetn_o;
	logic clk_cpu_en_o, clk_flash_en_o, clk_io_en_o, clk_adc_en_o;
	logic cpu_halt_o, irq_service_o, sleeping_o, osc_stop_o, bod_off_o;
	logic clock_output_pin_o, clock_output_pin_oe_o, pull_up_disable_o, pv;
	logic [1:0] int0_sense_o;
	sleep_mode_e sleep_mode_o;
	logic [31:0] seed = 32'h6e63f056;
	logic [3:0] sel;
	int fails = 0, compares = 0, n, r;
	always #50 clk_sys_i = ~clk_sys_i;
	// Short reset delays keep the run brief
	system_clock_prescale_sleep_ctrl #(.RST_4MS_CYC(20), .RST_64MS_CYC(40))
	DUT (.clk_sys_i, .resetn_i, .clock_source_select_fuses_i,
		.startup_time_fuses_i, .clock_output_fuse_i, .divide_by_eight_fuse_i,
		.avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
		.avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .sleep_instr_i,
		.wake_irq_i, .port_out_i, .port_oe_i, .low_power_osc_sel_o,
		.core_resetn_o, .clk_cpu_en_o, .clk_flash_en_o, .clk_io_en_o,
		.clk_adc_en_o, .cpu_halt_o, .irq_service_o, .sleeping_o, .sleep_mode_o,
		.osc_stop_o, .bod_off_o, .clock_output_pin_o, .clock_output_pin_oe_o,
		.pull_up_disable_o, .int0_sense_o);
	// --------------------------------
	// Helpers
	// --------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic int period(input logic [3:0] s);
		return 1 << ((s > 4'h8) ? 8 : int'(s));
	endfunction
	function automatic int rst_delay(input logic [1:0] c);
		return 14 + ((c == 2'h0) ? 0 : (c == 2'h1) ? 20 : 40);
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		if (fails == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Request held until waitrequest is seen low, data taken at that edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		avs_address_i <= a;
		avs_write_i <= wr;
		avs_read_i <= ~wr;
		avs_writedata_i <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 20);
		q = avs_readdata_o;
		if (n >= 20)
			fails++;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 8'h00);
		check(q, exp);
	endtask
	task automatic do_reset(input logic [1:0] c, input logic f);
		@(posedge clk_sys_i);
		seed = lfsr(seed);
		resetn_i <= 1'b0;
		startup_time_fuses_i <= c;
		divide_by_eight_fuse_i <= f;
		port_out_i <= seed[0];
		port_oe_i <= seed[1];
		repeat (3) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		check(clock_output_pin_o, port_out_i);
		check(core_resetn_o, 1'b0);
		@(posedge clk_sys_i);
		resetn_i <= 1'b1;
		n = 0;
		do begin
			@(negedge clk_sys_i);
			n++;
		end while (core_resetn_o !== 1'b1 && n < 100);
		check(n + 1 >= rst_delay(c) && n <= rst_delay(c) + 2, 1'b1);
	endtask
	// Gap between two divided enables, and pin rises seen within it
	task automatic ce_gap;
		n = 0;
		do begin
			@(negedge clk_sys_i);
			n++;
		end while (clk_cpu_en_o !== 1'b1 && n < 600);
		n = 0;
		r = 0;
		pv = clock_output_pin_o;
		do begin
			@(negedge clk_sys_i);
			n++;
			if (clock_output_pin_o === 1'b1 && pv === 1'b0)
				r++;
			pv = clock_output_pin_o;
		end while (clk_cpu_en_o !== 1'b1 && n < 600);
	endtask
	task automatic sleep_pulse;
		@(posedge clk_sys_i);
		sleep_instr_i <= 1'b1;
		@(posedge clk_sys_i);
		sleep_instr_i <= 1'b0;
		@(negedge clk_sys_i);
	endtask
	task automatic wake;
		@(posedge clk_sys_i);
		wake_irq_i <= 1'b1;
		n = 0;
		do begin
			@(negedge clk_sys_i);
			n++;
		end while (irq_service_o !== 1'b1 && n < 3000);
		@(posedge clk_sys_i);
		wake_irq_i <= 1'b0;
		@(negedge clk_sys_i);
		check(cpu_halt_o, 1'b0);
	endtask
	// --------------------------------
	// Scenarios
	// --------------------------------
	initial begin
		for (int c = 0; c < 3; c++) begin
			do_reset(c[1:0], c != 1);
			rd(4'h0, (c != 1) ? 32'h03 : 32'h00);
		end
		for (int k = 0; k < 16; k++) begin
			@(posedge clk_sys_i);
			clock_source_select_fuses_i <= k[3:0];
			@(negedge clk_sys_i);
			check(low_power_osc_sel_o, k == 3);
		end
		bus(1'b1, 4'h0, 8'h81);
		rd(4'h0, 32'h03);
		bus(1'b1, 4'h0, 8'h07);
		rd(4'h0, 32'h03);
		bus(1'b1, 4'h0, 8'h80);
		rd(4'h0, 32'h83);
		bus(1'b1, 4'h0, 8'h80);
		rd(4'h0, 32'h83);
		repeat (40) @(posedge clk_sys_i);
		rd(4'h0, 32'h03);
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			sel = (i == 0) ? 4'h8 : (i == 1) ? 4'h9 : (i == 2) ? 4'h0 :
				4'(seed % 9);
			bus(1'b1, 4'h0, 8'h80);
			// No wake request is raised between the two writes
			bus(1'b1, 4'h0, {4'h0, sel});
			rd(4'h0, {28'h0, sel});
			repeat (3) ce_gap;
			check(n, period(sel));
			if (sel != 4'h0)
				check(r, 1);
			check(clock_output_pin_oe_o, 1'b1);
			rd(4'h8, 32'h00);
		end
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, 4'h4, {3'b001, m[1:0], 3'b000});
			sleep_pulse;
			check(sleeping_o, 1'b1);
			check({30'h0, sleep_mode_o}, m);
			check(osc_stop_o, m[1]);
			wake;
			check(n >= 3 * period(sel), 1'b1);
		end
		bus(1'b1, 4'h4, 8'h10);
		sleep_pulse;
		check(sleeping_o, 1'b0);
		bus(1'b1, 4'h4, 8'h20);
		sleep_pulse;
		do_reset(2'h0, 1'b0);
		check(sleeping_o, 1'b0);
		check(cpu_halt_o, 1'b0);
		bus(1'b1, 4'h4, 8'ha4);
		bus(1'b1, 4'h4, 8'ha0);
		repeat (3) @(posedge clk_sys_i);
		sleep_pulse;
		check(bod_off_o, 1'b1);
		wake;
		bus(1'b1, 4'h4, 8'ha0);
		sleep_pulse;
		check(bod_off_o, 1'b0);
		wake;
		final_report;
	end
	// Cut a hang short well beyond the expected run length
	initial begin
		repeat (90000) @(posedge clk_sys_i);
		fails++;
		final_report;
	end
endmodule // tb
